/* verilog/i2c_assist_pkg.sv */
package i2c_assist_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_INT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h13;
    localparam logic [7:0] IDX_PORT_CONTROL = 8'h14;
    localparam logic [7:0] IDX_PORT_C_DIR = 8'h87;
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_SLAVE_ADDR = 8'h93;
    localparam logic [7:0] IDX_PORT_STATUS = 8'h94;
    // event status (read only), clear (write only) and enable
    localparam logic [7:0] IDX_EVT_STATUS = 8'hA0;
    localparam logic [7:0] IDX_EVT_CLEAR = 8'hA1;
    localparam logic [7:0] IDX_EVT_ENABLE = 8'hA2;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_C_DIR = 8'hFF;
    // software-writable bits
    localparam logic [7:0] MASK_IRQ_REGS = 8'h4F;
    localparam logic [7:0] MASK_STATUS_WR = 8'hC0;
    // control register fields
    localparam int CTL_OVERFLOW = 6;
    localparam int CTL_ENABLE = 5;
    // status register fields
    localparam int STAT_STOP = 4;
    localparam int STAT_START = 3;
    localparam int STAT_BUF_FULL = 0;
    // flag and enable position of the port interrupt
    localparam int PIR_PORT_IRQ = 3;
    // bus line direction bits
    localparam int DIR_SDA = 4;
    localparam int DIR_SCL = 3;
    // event bits
    localparam int EVT_START = 0;
    localparam int EVT_STOP = 1;
    localparam int EVT_BYTE = 2;
    // port mode field values
    localparam logic [3:0] MODE_SLAVE7 = 4'h6;
    localparam logic [3:0] MODE_SLAVE10 = 4'h7;
    localparam logic [3:0] MODE_FW_MASTER = 4'hB;
    localparam logic [3:0] MODE_SLAVE7_SS = 4'hE;
    localparam logic [3:0] MODE_SLAVE10_SS = 4'hF;
    // bit counts within a byte frame
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    // byte frame phase, gray along idle, address, data
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_ADDR = 2'h1,
        PH_DATA = 2'h3,
        PH_SKIP = 2'h2
    } phase_t;
endpackage

/* verilog/line_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser for a bus line with an agreement filter
module line_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // raw pin and filtered level
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic [2:0] ff; // ff[0] feeds only ff[1]
        logic lvl;      // filtered level
    } sync_t;

    sync_t q;
    sync_t d;

    // shift in the pin; a change counts once stages two and three agree
    always_comb begin
        d = q;
        d.ff = {q.ff[1:0], pin_i};
        if (q.ff[1] == q.ff[2]) begin
            d.lvl = q.ff[2];
        end
    end

    // idle bus lines are high, so reset to high
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
endmodule // line_sync

/* verilog/bus_cond_detect.sv */
`timescale 1ns/1ps
// finds start, stop and clock edges on the synchronised bus lines
module bus_cond_detect (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // synchronised lines
    input wire logic scl_i,
    input wire logic sda_i,
    // one-cycle pulses
    output logic start_o,
    output logic stop_o,
    output logic rise_o,
    output logic fall_o
);
    typedef struct packed {
        logic scl; // line levels one cycle ago
        logic sda;
    } prev_t;

    prev_t q;
    prev_t d;

    // remember the last levels
    always_comb begin
        d = q;
        d.scl = scl_i;
        d.sda = sda_i;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    // data falling or rising while the clock stays high
    assign start_o = q.scl && scl_i && q.sda && !sda_i;
    assign stop_o = q.scl && scl_i && !q.sda && sda_i;
    // clock edges frame the data bits
    assign rise_o = !q.scl && scl_i;
    assign fall_o = q.scl && !scl_i;
endmodule // bus_cond_detect

/* verilog/i2c_bus_assist.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - reset or port disable clears start/stop bits
// - start/stop bits follow the latest bus condition
// - output-direction bus line is driven low
// - flag set on matched byte done, and on start, stop in ss_irq modes only
// - interrupt enabled while busy fires on stop in ss_irq modes
// - slave keeps receiving, acks its own address
// - bus tracking needs the port enable bit; line direction drive does not
module i2c_bus_assist (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register bus
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // bus clock line, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // bus data line, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic waitreq;                // bus answer pending
        logic [31:0] rdata;           // read data
        logic [7:0] int_control;      // global enables, plain storage
        logic [7:0] irq_flags;        // peripheral flags
        logic [7:0] irq_enables;      // peripheral enables
        logic [7:0] serial_buffer;    // last received byte
        logic [7:0] port_control;     // enable, overflow, mode
        logic [7:0] port_c_direction; // line directions
        logic [7:0] bus_slave_address;
        logic [7:0] port_status;      // stop, start, buffer full
        logic [2:0] evt_status;       // sticky events
        logic [2:0] evt_enable;       // event mask
        logic irq;
        logic scl_oe;
        logic sda_oe;
        i2c_assist_pkg::phase_t phase;
        logic [3:0] bit_cnt;          // clock rises in this byte
        logic [7:0] shift;            // incoming bits
        logic ack_drive;              // pulling data low for ack
        logic byte_pend;              // byte matched, flag at ack end
    } state_t;

    state_t q;
    state_t d;

    // synchronised lines and their conditions
    logic scl_s;
    logic sda_s;
    logic start_p;
    logic stop_p;
    logic rise_p;
    logic fall_p;
    // decoded control
    logic en;
    logic slave_on;
    logic ss_irq;
    logic [3:0] mode;

    line_sync u_scl_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_i(scl_i),
        .level_o(scl_s)
    );

    line_sync u_sda_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_i(sda_i),
        .level_o(sda_s)
    );

    bus_cond_detect u_detect (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .scl_i(scl_s),
        .sda_i(sda_s),
        .start_o(start_p),
        .stop_o(stop_p),
        .rise_o(rise_p),
        .fall_o(fall_p)
    );

    // mode decode; master mode leaves the slave logic idle
    assign en = q.port_control[i2c_assist_pkg::CTL_ENABLE];
    assign mode = q.port_control[3:0];
    assign slave_on = en && (mode == i2c_assist_pkg::MODE_SLAVE7
        || mode == i2c_assist_pkg::MODE_SLAVE10
        || mode == i2c_assist_pkg::MODE_SLAVE7_SS
        || mode == i2c_assist_pkg::MODE_SLAVE10_SS);
    // modes that interrupt on start and stop
    assign ss_irq = mode == i2c_assist_pkg::MODE_FW_MASTER
        || mode == i2c_assist_pkg::MODE_SLAVE7_SS
        || mode == i2c_assist_pkg::MODE_SLAVE10_SS;

    // next state: bus access first, hardware events after so they win
    always_comb begin
        logic [7:0] rd;
        logic [7:0] wd;
        logic [2:0] ev;
        logic [2:0] clr;
        logic match;
        rd = 8'h00;
        wd = writedata[7:0];
        ev = 3'h0;
        clr = 3'h0;
        match = 1'b0;
        d = q;
        // read mux; write-only and unmapped words read zero
        case (address[9:2])
            i2c_assist_pkg::IDX_INT_CONTROL: rd = q.int_control;
            i2c_assist_pkg::IDX_IRQ_FLAGS: rd = q.irq_flags;
            i2c_assist_pkg::IDX_SERIAL_BUFFER: rd = q.serial_buffer;
            i2c_assist_pkg::IDX_PORT_CONTROL: rd = q.port_control;
            i2c_assist_pkg::IDX_PORT_C_DIR: rd = q.port_c_direction;
            i2c_assist_pkg::IDX_IRQ_ENABLES: rd = q.irq_enables;
            i2c_assist_pkg::IDX_SLAVE_ADDR: rd = q.bus_slave_address;
            i2c_assist_pkg::IDX_PORT_STATUS: rd = q.port_status;
            i2c_assist_pkg::IDX_EVT_STATUS: rd = {5'h00, q.evt_status};
            i2c_assist_pkg::IDX_EVT_ENABLE: rd = {5'h00, q.evt_enable};
            default: rd = 8'h00;
        endcase
        if ((read || write) && q.waitreq) begin
            // first cycle of a request: answer next cycle
            d.waitreq = 1'b0;
            d.rdata = {24'h000000, rd};
        end else if (read || write) begin
            // completing edge: the write lands here
            d.waitreq = 1'b1;
            if (write && byteenable[0]) begin
                case (address[9:2])
                    i2c_assist_pkg::IDX_INT_CONTROL: d.int_control = wd;
                    i2c_assist_pkg::IDX_IRQ_FLAGS: begin
                        d.irq_flags = wd & i2c_assist_pkg::MASK_IRQ_REGS;
                    end
                    i2c_assist_pkg::IDX_SERIAL_BUFFER: d.serial_buffer = wd;
                    i2c_assist_pkg::IDX_PORT_CONTROL: d.port_control = wd;
                    i2c_assist_pkg::IDX_PORT_C_DIR: d.port_c_direction = wd;
                    i2c_assist_pkg::IDX_IRQ_ENABLES: begin
                        d.irq_enables = wd & i2c_assist_pkg::MASK_IRQ_REGS;
                    end
                    i2c_assist_pkg::IDX_SLAVE_ADDR: d.bus_slave_address = wd;
                    i2c_assist_pkg::IDX_PORT_STATUS: begin
                        // only sample and edge bits are writable
                        d.port_status = (q.port_status & ~i2c_assist_pkg::MASK_STATUS_WR)
                            | (wd & i2c_assist_pkg::MASK_STATUS_WR);
                    end
                    i2c_assist_pkg::IDX_EVT_CLEAR: clr = wd[2:0];
                    i2c_assist_pkg::IDX_EVT_ENABLE: d.evt_enable = wd[2:0];
                    default: begin
                    end
                endcase
            end
            // reading the buffer frees it
            if (read && address[9:2] == i2c_assist_pkg::IDX_SERIAL_BUFFER) begin
                d.port_status[i2c_assist_pkg::STAT_BUF_FULL] = 1'b0;
            end
        end
        // bus tracking
        if (!en) begin
            // disabled port forgets the bus and clears both bits
            d.port_status[i2c_assist_pkg::STAT_START] = 1'b0;
            d.port_status[i2c_assist_pkg::STAT_STOP] = 1'b0;
            d.phase = i2c_assist_pkg::PH_IDLE;
            d.bit_cnt = 4'h0;
            d.ack_drive = 1'b0;
            d.byte_pend = 1'b0;
        end else if (start_p) begin
            // start, also repeated start: latest condition wins
            d.port_status[i2c_assist_pkg::STAT_START] = 1'b1;
            d.port_status[i2c_assist_pkg::STAT_STOP] = 1'b0;
            d.phase = i2c_assist_pkg::PH_ADDR;
            d.bit_cnt = 4'h0;
            d.ack_drive = 1'b0;
            d.byte_pend = 1'b0;
            ev[i2c_assist_pkg::EVT_START] = ss_irq;
        end else if (stop_p) begin
            // stop: bus is free again
            d.port_status[i2c_assist_pkg::STAT_STOP] = 1'b1;
            d.port_status[i2c_assist_pkg::STAT_START] = 1'b0;
            d.phase = i2c_assist_pkg::PH_IDLE;
            d.bit_cnt = 4'h0;
            d.ack_drive = 1'b0;
            d.byte_pend = 1'b0;
            ev[i2c_assist_pkg::EVT_STOP] = ss_irq;
        end else if (q.phase != i2c_assist_pkg::PH_IDLE) begin
            if (rise_p && q.bit_cnt < i2c_assist_pkg::BITS_PER_BYTE) begin
                // data is sampled on the clock rise, msb first
                d.shift = {q.shift[6:0], sda_s};
                d.bit_cnt = q.bit_cnt + 4'h1;
            end else if (fall_p && q.bit_cnt == i2c_assist_pkg::BITS_PER_BYTE) begin
                // eighth fall: decide whether to acknowledge
                d.bit_cnt = i2c_assist_pkg::ACK_SLOT;
                // receiving goes on even when our own master lost
                match = slave_on && (q.phase == i2c_assist_pkg::PH_DATA
                    || (q.phase == i2c_assist_pkg::PH_ADDR
                    && q.shift[7:1] == q.bus_slave_address[7:1]));
                if (q.phase == i2c_assist_pkg::PH_ADDR) begin
                    d.phase = match ? i2c_assist_pkg::PH_DATA : i2c_assist_pkg::PH_SKIP;
                end
                if (match) begin
                    d.byte_pend = 1'b1;
                    if (!q.port_status[i2c_assist_pkg::STAT_BUF_FULL]
                        && !q.port_control[i2c_assist_pkg::CTL_OVERFLOW]) begin
                        d.serial_buffer = q.shift;
                        d.port_status[i2c_assist_pkg::STAT_BUF_FULL] = 1'b1;
                        d.ack_drive = 1'b1;
                    end else if (q.port_status[i2c_assist_pkg::STAT_BUF_FULL]) begin
                        // full buffer: no ack, byte lost
                        d.port_control[i2c_assist_pkg::CTL_OVERFLOW] = 1'b1;
                    end
                end
            end else if (fall_p && q.bit_cnt == i2c_assist_pkg::ACK_SLOT) begin
                // ninth fall ends the byte and raises its flag if the byte matched
                d.bit_cnt = 4'h0;
                d.ack_drive = 1'b0;
                d.byte_pend = 1'b0;
                ev[i2c_assist_pkg::EVT_BYTE] = q.byte_pend;
            end
        end
        // sticky events: a set in the clearing cycle survives
        d.evt_status = (q.evt_status & ~clr) | ev;
        if (|ev) begin
            d.irq_flags[i2c_assist_pkg::PIR_PORT_IRQ] = 1'b1;
        end
        d.irq = |(d.evt_status & d.evt_enable);
        // direction bit low pulls the line low, latch value ignored
        d.scl_oe = !q.port_c_direction[i2c_assist_pkg::DIR_SCL];
        d.sda_oe = !q.port_c_direction[i2c_assist_pkg::DIR_SDA] || q.ack_drive;
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.waitreq <= 1'b1;
            q.int_control <= i2c_assist_pkg::RST_ZERO;
            q.port_c_direction <= i2c_assist_pkg::RST_PORT_C_DIR;
        end else begin
            q <= d;
        end
    end

    // outputs; open-drain lines only ever pull low
    assign readdata = q.rdata;
    assign waitrequest = q.waitreq;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign irq = q.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // an address byte that matches and finds room
    sequence addr_hit_s;
        en && slave_on && !start_p && !stop_p && fall_p
            && q.phase == i2c_assist_pkg::PH_ADDR
            && q.bit_cnt == i2c_assist_pkg::BITS_PER_BYTE
            && q.shift[7:1] == q.bus_slave_address[7:1]
            && !q.port_status[i2c_assist_pkg::STAT_BUF_FULL]
            && !q.port_control[i2c_assist_pkg::CTL_OVERFLOW];
    endsequence

    // end of the ack slot of a matched byte
    sequence ack_end_s;
        en && !start_p && !stop_p && fall_p && q.byte_pend
            && q.bit_cnt == i2c_assist_pkg::ACK_SLOT;
    endsequence

    off_clears_bits_a: assert property (!en |=> !q.port_status[i2c_assist_pkg::STAT_START]
        && !q.port_status[i2c_assist_pkg::STAT_STOP])
        else $error("start/stop bits not cleared while disabled");
    off_idle_a: assert property (!en |=> q.phase == i2c_assist_pkg::PH_IDLE)
        else $error("frame tracking active while disabled");
    start_latch_a: assert property (en && start_p |=>
        q.port_status[i2c_assist_pkg::STAT_START] && !q.port_status[i2c_assist_pkg::STAT_STOP])
        else $error("start condition not latched");
    stop_latch_a: assert property (en && stop_p |=> q.port_status[i2c_assist_pkg::STAT_STOP]
        && !q.port_status[i2c_assist_pkg::STAT_START])
        else $error("stop condition not latched");
    scl_drive_low_a: assert property (1'b1 |=>
        scl_oe == !$past(q.port_c_direction[i2c_assist_pkg::DIR_SCL]) && !scl_o && !sda_o)
        else $error("clock line drive does not follow direction");
    start_flag_a: assert property (en && start_p && ss_irq |=>
        q.irq_flags[i2c_assist_pkg::PIR_PORT_IRQ] && q.evt_status[i2c_assist_pkg::EVT_START])
        else $error("start did not raise the port flag");
    byte_flag_a: assert property (ack_end_s |=> q.evt_status[i2c_assist_pkg::EVT_BYTE]
        && q.irq_flags[i2c_assist_pkg::PIR_PORT_IRQ] && !q.ack_drive)
        else $error("byte end did not raise the port flag");
    master_no_ack_a: assert property ($rose(q.ack_drive) |-> $past(slave_on))
        else $error("ack driven with slave logic idle");
    stop_irq_a: assert property (en && stop_p && ss_irq && !write
        && q.evt_enable[i2c_assist_pkg::EVT_STOP] |=> irq)
        else $error("stop did not interrupt");
    addr_ack_a: assert property (addr_hit_s |=> q.ack_drive ##1 sda_oe)
        else $error("matching address not acknowledged");
    start_detect_a: assert property (start_p |-> scl_s && $past(sda_s) && !sda_s)
        else $error("start pulse without data fall under high clock");
    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one cycle");

    // a matched data byte that finds the buffer still full
    sequence full_hit_s;
        en && slave_on && !start_p && !stop_p && fall_p
            && q.phase == i2c_assist_pkg::PH_DATA
            && q.bit_cnt == i2c_assist_pkg::BITS_PER_BYTE
            && q.port_status[i2c_assist_pkg::STAT_BUF_FULL];
    endsequence

    // a stop that the selected mode is asked to flag
    sequence stop_flag_s;
        en && stop_p && ss_irq;
    endsequence

    stop_flag_a: assert property (stop_flag_s |=>
        q.irq_flags[i2c_assist_pkg::PIR_PORT_IRQ] && q.evt_status[i2c_assist_pkg::EVT_STOP])
        else $error("stop did not raise the port flag");
    full_overflow_a: assert property (full_hit_s |=>
        q.port_control[i2c_assist_pkg::CTL_OVERFLOW] && !q.ack_drive)
        else $error("full buffer did not flag overflow");
    sda_drive_low_a: assert property (1'b1 |=> sda_oe ==
        (!$past(q.port_c_direction[i2c_assist_pkg::DIR_SDA]) || $past(q.ack_drive)))
        else $error("data line drive does not follow direction");
    stop_detect_a: assert property (stop_p |-> scl_s && !$past(sda_s) && sda_s)
        else $error("stop pulse without data rise under high clock");
endmodule // i2c_bus_assist

/* tb/bus_partner.sv */
`timescale 1ns/1ps
// far-side master on the two-wire bus; it only pulls lines low
module bus_partner (
    // system clock paces the link clock
    input wire logic clk_sys,
    // data line as resolved on the wire
    input wire logic sda_line,
    // open-drain pulls, high means pull low
    output logic scl_low,
    output logic sda_low
);
    // released at start, pull-ups leave the bus idle high
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // one 80 ns phase of the 240 ns link clock at 4 ns per cycle; a bit is high one phase, low two
    task automatic half();
        repeat (20) @(posedge clk_sys);
    endtask
    // taken only from idle or after a stop
    task automatic start_cond();
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b1;
        half();
    endtask
    // data rises while the clock is high; the clock stays high after
    task automatic stop_cond();
        sda_low <= 1'b1;
        half();
        scl_low <= 1'b0;
        half();
        sda_low <= 1'b0;
        half();
    endtask
    // msb first, a one is a released line, ninth slot released for ack
    task automatic send_byte(input logic [7:0] b, output logic ack, output logic lost);
        logic [8:0] w;
        w = {b, 1'b1};
        lost = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            sda_low <= ~w[i] & ~lost; // a lost master keeps data released
            half();
            scl_low <= 1'b0;
            half();
            if (i == 0) begin
                ack = ~sda_line;
            end else if (w[i] && !sda_line) begin
                lost = 1'b1; // reported to the caller through lost
            end
            scl_low <= 1'b1;
            half();
        end
    endtask
endmodule // bus_partner

/* tb/i2c_bus_state_master_assist_tb.sv */
`timescale 1ns/1ps
// bench: register model, far-side master and event checks
module i2c_bus_state_master_assist_tb;
    // clock, reset and register bus
    logic clk_sys;
    logic arst_n;
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    // line drives and interrupt
    logic scl_o, scl_oe, sda_o, sda_oe, irq, p_scl, p_sda;
    // wired-and with pull-ups
    wire scl_w = (scl_oe ? scl_o : 1'b1) & ~p_scl;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~p_sda;
    int n_fail = 0;
    int checks = 0;
    int seed = 32'h67E3E001;
    int model[int]; // expected register contents, absent means zero
    logic [7:0] rd;
    logic ack;
    logic lost;
    logic [7:0] v;
    logic flag_ss;
    logic [7:0] all_regs[$] = '{8'h0B, 8'h0C, 8'h13, 8'h14, 8'h87, 8'h8C, 8'h93, 8'h94,
        8'hA0, 8'hA1, 8'hA2, 8'h55};
    logic [7:0] rw_regs[$] = '{8'h0B, 8'h0C, 8'h8C, 8'h93, 8'h55};
    logic [3:0] modes[$] = '{4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
    i2c_bus_assist DUT (.clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    bus_partner p (.clk_sys(clk_sys), .sda_line(sda_w), .scl_low(p_scl), .sda_low(p_sda));
    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        address <= {idx, 2'h0};
        writedata <= {24'h0, wd};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 40) begin
            n_fail++;
            final_report();
        end
        @(posedge clk_sys);
    endtask
    // write and keep the model in step; only plain storage is remembered
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] wd);
        access(1'b1, idx, wd);
        if (idx inside {8'h0C, 8'h8C}) model[idx] = wd & 8'h4F;
        else if (idx inside {8'h0B, 8'h14, 8'h87, 8'h93, 8'hA2}) model[idx] = wd;
        else if (idx == 8'hA1) model[8'hA0] = model[8'hA0] & ~wd;
    endtask
    task automatic reg_chk(input logic [7:0] idx);
        access(1'b0, idx, 8'h00);
        check($sformatf("reg %h", idx), model.exists(idx) ? model[idx] : 0, rd);
    endtask
    // start, stop and buffer-full bits only; other status bits are not modelled
    task automatic stat_chk(input logic [7:0] exp);
        access(1'b0, 8'h94, 8'h00);
        check("status", exp, rd & 8'h19);
    endtask
    initial begin
        arst_n = 1'b0;
        address = 10'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        model[8'h87] = 8'hFF;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // reset values, including an unmapped index
        check("pins", 8'h00, {3'h0, scl_o, sda_o, irq, scl_oe, sda_oe});
        foreach (all_regs[i]) reg_chk(all_regs[i]);
        repeat (3) begin
            foreach (rw_regs[i]) reg_wr(rw_regs[i], 8'($random(seed)));
            foreach (rw_regs[i]) reg_chk(rw_regs[i]);
        end
        reg_wr(8'h94, 8'h00);
        // output direction means a low drive, one cycle after the write
        repeat (4) begin
            v = 8'($random(seed));
            reg_wr(8'h87, v);
            @(posedge clk_sys);
            check("line drive", {6'h0, ~v[3], ~v[4]}, {6'h0, scl_oe, sda_oe});
        end
        reg_wr(8'h87, 8'hFF);
        reg_wr(8'hA2, 8'h07);
        // start and stop in each mode; only some modes flag them
        foreach (modes[i]) begin
            flag_ss = modes[i] inside {4'hB, 4'hE, 4'hF};
            reg_wr(8'h14, {4'h2, modes[i]});
            p.start_cond();
            stat_chk(8'h08);
            model[8'hA0] = flag_ss ? 1 : 0;
            reg_chk(8'hA0);
            check("irq", {7'h0, flag_ss}, {7'h0, irq});
            reg_wr(8'hA1, 8'h07);
            p.stop_cond();
            stat_chk(8'h10);
            model[8'hA0] = flag_ss ? 2 : 0;
            reg_chk(8'hA0);
            reg_wr(8'hA1, 8'h07);
        end
        // disabling clears the bits and stops detection
        reg_wr(8'h14, 8'h0B);
        stat_chk(8'h00);
        p.start_cond();
        stat_chk(8'h00);
        reg_chk(8'hA0);
        p.stop_cond();
        // firmware master mode: no ack, stop interrupt enabled while busy
        reg_wr(8'h14, 8'h2B);
        reg_wr(8'hA2, 8'h00);
        p.start_cond();
        reg_wr(8'hA2, 8'h02);
        p.send_byte(8'h3C, ack, lost);
        check("master ack", 8'h00, {7'h0, ack});
        check("busy irq", 8'h00, {7'h0, irq});
        p.stop_cond();
        check("stop irq", 8'h01, {7'h0, irq});
        model[8'hA0] = 3;
        reg_chk(8'hA0);
        reg_wr(8'hA1, 8'h07);
        // slave mode with start/stop events: address, data, overflow
        reg_wr(8'h93, 8'hA4);
        reg_wr(8'h14, 8'h2E);
        p.start_cond();
        p.send_byte(8'hA4, ack, lost);
        check("address ack", 8'h01, {7'h0, ack});
        stat_chk(8'h09);
        model[8'hA0] = 5;
        model[8'h0C] = model[8'h0C] | 8'h08;
        reg_chk(8'hA0);
        reg_chk(8'h0C);
        model[8'h13] = 8'hA4;
        reg_chk(8'h13);
        p.send_byte(8'h5A, ack, lost);
        check("data ack", 8'h01, {7'h0, ack});
        p.send_byte(8'hC3, ack, lost);
        check("overflow ack", 8'h00, {7'h0, ack});
        model[8'h14] = 8'h6E;
        reg_chk(8'h14);
        model[8'h13] = 8'h5A;
        reg_chk(8'h13);
        p.stop_cond();
        stat_chk(8'h10);
        // a reset in mid-run clears the stop bit left by the last frame
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        stat_chk(8'h00);
        final_report();
    end
endmodule // i2c_bus_state_master_assist_tb
